// >>> logic/txcrm_top.v
// Clock plan, reset distribution and address decode of the tx subsystem.
// Functional notes
// RULE_01 - With 16-bit PHY path, link clock equals lane line rate over 20.
// RULE_02 - Link clock is 81, 135, 270 or 405 MHz per lane rate.
// RULE_03 - External protection clock is supplied at half the link clock.
// RULE_04 - Most transmit logic runs on the PHY transmit output clock.
// RULE_05 - Video clock is at least total pixels per second over pixels/clock.
// RULE_06 - With 4:2:0 the video clock is halved.
// RULE_07 - Stream clock is stated from link clock by M and N values.
// RULE_08 - Register domain runs up to 135 MHz; aux clock derives from it.
// RULE_09 - Low register-bus reset returns all programming registers to reset.
// RULE_10 - Each stream has its own active-high video pipe reset.
// RULE_11 - Each stream input has its own active-low reset.
// RULE_12 - One more active-low reset serves output logic of streams 1, 2.
// RULE_13 - A 19-bit register window is decoded from offset zero.
// RULE_14 - Single stream: core, timing ctl, protection ctl, timer pages.
// RULE_15 - Multi stream: timing ctls 2 to 4; no protection ctl or timer.
// RULE_16 - Each reset is released synchronously to its domain clock.
`include "txcrm_defines.vh"
module txcrm_top
(
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire multi_stream,
  input wire [`TXCRM_ADDR_W-1:0] reg_addr,
  input wire [`TXCRM_RATE_W-1:0] link_rate_sel,
  input wire [`TXCRM_NSTREAM-1:0] video_pipe_reset_req,
  input wire [`TXCRM_NSTREAM-1:0] stream_input_reset_req_n,
  input wire stream_output_reset_req_n,
  input wire [23:0] mvid_value,
  input wire [23:0] nvid_value,
  output reg [`TXCRM_SEL_W-1:0] target_sel,
  output reg decode_miss,
  output reg [`TXCRM_ADDR_W-1:0] local_offset,
  output reg [8:0] link_clock_mhz,
  output reg [12:0] line_rate_mbps,
  output reg [8:0] ext_prot_clock_mhz,
  output reg prog_reg_reset,
  output reg [`TXCRM_NSTREAM-1:0] video_pipe_reset,
  output reg [`TXCRM_NSTREAM-1:0] stream_input_reset_n,
  output reg stream_output_reset_n,
  output reg [23:0] stream_m_value,
  output reg [23:0] stream_n_value,
  output reg ratio_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers.

  // Maps a 4 KB page to one target select depending on stream mode.
  function [`TXCRM_SEL_W-1:0] page_sel;
    input [`TXCRM_PAGE_W-1:0] page;
    input mst;
    begin
      page_sel = `TXCRM_SEL_NONE;
      if (page == `TXCRM_PAGE_CORE)
        page_sel = `TXCRM_SEL_CORE; // [RULE_14] [RULE_15]
      else if (page == `TXCRM_PAGE_TC0)
        page_sel = `TXCRM_SEL_TC0; // [RULE_14] [RULE_15]
      else if (mst)
      begin
        // Protection controller and timer are absent here.
        if (page == `TXCRM_PAGE_TC1)
          page_sel = `TXCRM_SEL_TC1; // [RULE_15]
        else if (page == `TXCRM_PAGE_TC2)
          page_sel = `TXCRM_SEL_TC2; // [RULE_15]
        else if (page == `TXCRM_PAGE_TC3)
          page_sel = `TXCRM_SEL_TC3; // [RULE_15]
      end
      else
      begin
        if (page == `TXCRM_PAGE_HDCP)
          page_sel = `TXCRM_SEL_HDCP; // [RULE_14]
        else if (page == `TXCRM_PAGE_TMR)
          page_sel = `TXCRM_SEL_TMR; // [RULE_14]
      end
    end
  endfunction

  // Returns link clock in MHz for a lane rate code.
  function [8:0] lnk_mhz;
    input [`TXCRM_RATE_W-1:0] rate;
    begin
      case (rate)
        `TXCRM_RATE_162: lnk_mhz = `TXCRM_LNK_MHZ_162;
        `TXCRM_RATE_270: lnk_mhz = `TXCRM_LNK_MHZ_270;
        `TXCRM_RATE_540: lnk_mhz = `TXCRM_LNK_MHZ_540;
        default: lnk_mhz = `TXCRM_LNK_MHZ_810;
      endcase
    end
  endfunction

  // Returns lane line rate in Mb/s for a lane rate code.
  function [12:0] line_mbps;
    input [`TXCRM_RATE_W-1:0] rate;
    begin
      case (rate)
        `TXCRM_RATE_162: line_mbps = `TXCRM_LINE_MBPS_162;
        `TXCRM_RATE_270: line_mbps = `TXCRM_LINE_MBPS_270;
        `TXCRM_RATE_540: line_mbps = `TXCRM_LINE_MBPS_540;
        default: line_mbps = `TXCRM_LINE_MBPS_810;
      endcase
    end
  endfunction

  // Combines the bus reset with one domain's own request, active high.
  function rst_req;
    input bus_rst_n;
    input req;
    begin
      rst_req = ~bus_rst_n | req;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchronisers, one per reset domain.

  wire bus_rst_sync;
  wire out_rst_sync;
  wire [`TXCRM_NSTREAM-1:0] vid_rst_sync;
  wire [`TXCRM_NSTREAM-1:0] in_rst_sync;

  // Register-bus reset: releases all programming registers together.
  txcrm_rst_sync u_bus_rst
  (
    .clk(clk),
    .ce(ce),
    .rst_in(~rst_n),
    .rst_out(bus_rst_sync)
  );

  // Output-side reset shared by streams one and two.
  txcrm_rst_sync u_out_rst
  (
    .clk(clk),
    .ce(ce),
    .rst_in(rst_req(rst_n, ~stream_output_reset_req_n)),
    .rst_out(out_rst_sync)
  );

  // One video pipe and one input reset for every stream.
  genvar gi;
  generate
    for (gi = 0; gi < `TXCRM_NSTREAM; gi = gi + 1)
    begin : g_strm
      txcrm_rst_sync u_vid_rst
      (
        .clk(clk),
        .ce(ce),
        .rst_in(rst_req(rst_n, video_pipe_reset_req[gi])),
        .rst_out(vid_rst_sync[gi])
      );
      txcrm_rst_sync u_in_rst
      (
        .clk(clk),
        .ce(ce),
        .rst_in(rst_req(rst_n, ~stream_input_reset_req_n[gi])),
        .rst_out(in_rst_sync[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  wire [`TXCRM_SEL_W-1:0] sel_next;
  wire [8:0] lnk_next;

  assign sel_next = page_sel(reg_addr[`TXCRM_ADDR_W-1:`TXCRM_PAGE_LSB],
    multi_stream); // [RULE_13]
  assign lnk_next = lnk_mhz(link_rate_sel); // [RULE_01] [RULE_02] [RULE_04]

  // Reset outputs follow their synchronised sources every enabled cycle.
  always @(posedge clk)
  begin
    if (ce)
    begin
      prog_reg_reset <= bus_rst_sync; // [RULE_09]
      video_pipe_reset <= vid_rst_sync; // [RULE_10]
      stream_input_reset_n <= ~in_rst_sync; // [RULE_11]
      stream_output_reset_n <= ~out_rst_sync; // [RULE_12]
    end
  end

  // Decode and clock plan registers, cleared by the bus reset.
  // They sit in the processor register domain: clk may run up to 135 MHz,
  // and the aux channel timing of the subsystem is derived from this clock.
  // The reset also waits for an enabled edge, so a frozen block holds state.
  always @(posedge clk) // [RULE_08]
  begin
    if (ce)
    begin
      if (bus_rst_sync)
      begin
        target_sel <= `TXCRM_SEL_NONE;
        decode_miss <= 1'b0;
        local_offset <= {`TXCRM_ADDR_W{1'b0}};
        link_clock_mhz <= 9'h000;
        line_rate_mbps <= 13'h0000;
        ext_prot_clock_mhz <= 9'h000;
        stream_m_value <= 24'h000000;
        stream_n_value <= 24'h000000;
        ratio_valid <= 1'b0;
      end
      else
      begin
        target_sel <= sel_next; // [RULE_14] [RULE_15]
        decode_miss <= (sel_next == `TXCRM_SEL_NONE);
        local_offset <= {{`TXCRM_PAGE_W{1'b0}},
          reg_addr[`TXCRM_PAGE_LSB-1:0]}; // [RULE_13]
        link_clock_mhz <= lnk_next; // [RULE_02]
        line_rate_mbps <= line_mbps(link_rate_sel); // [RULE_01]
        ext_prot_clock_mhz <= {1'b0, lnk_next[8:1]}; // [RULE_03]
        stream_m_value <= mvid_value; // [RULE_07]
        stream_n_value <= nvid_value; // [RULE_07]
        ratio_valid <= (nvid_value != 24'h000000); // [RULE_07]
      end
    end
  end

endmodule

// >>> logic/txcrm_defines.vh
// Constants for the transmit subsystem clock, reset and address map block.
`ifndef TXCRM_DEFINES_VH
`define TXCRM_DEFINES_VH
`define TXCRM_ADDR_W 19
`define TXCRM_PAGE_LSB 12
`define TXCRM_PAGE_W 7
`define TXCRM_PAGE_CORE 7'h00
`define TXCRM_PAGE_TC0 7'h01
`define TXCRM_PAGE_TC1 7'h02
`define TXCRM_PAGE_TC2 7'h03
`define TXCRM_PAGE_TC3 7'h04
`define TXCRM_PAGE_HDCP 7'h02
`define TXCRM_PAGE_TMR 7'h03
`define TXCRM_SEL_W 7
`define TXCRM_SEL_CORE 7'h01
`define TXCRM_SEL_TC0 7'h02
`define TXCRM_SEL_TC1 7'h04
`define TXCRM_SEL_TC2 7'h08
`define TXCRM_SEL_TC3 7'h10
`define TXCRM_SEL_HDCP 7'h20
`define TXCRM_SEL_TMR 7'h40
`define TXCRM_SEL_NONE 7'h00
`define TXCRM_PHY_W 16
`define TXCRM_LINE_DIV 20
`define TXCRM_RATE_W 2
`define TXCRM_RATE_162 2'h0
`define TXCRM_RATE_270 2'h1
`define TXCRM_RATE_540 2'h2
`define TXCRM_RATE_810 2'h3
`define TXCRM_LNK_MHZ_162 9'h051
`define TXCRM_LNK_MHZ_270 9'h087
`define TXCRM_LNK_MHZ_540 9'h10e
`define TXCRM_LNK_MHZ_810 9'h195
`define TXCRM_LINE_MBPS_162 13'h0654
`define TXCRM_LINE_MBPS_270 13'h0a8c
`define TXCRM_LINE_MBPS_540 13'h1518
`define TXCRM_LINE_MBPS_810 13'h1fa4
`define TXCRM_CPU_MAX_MHZ 8'h87
`define TXCRM_NSTREAM 4
`define TXCRM_SYNC_STAGES 2
`endif

// >>> logic/txcrm_rst_sync.v
// Reset release synchroniser for one domain, active high output.
module txcrm_rst_sync
(
  input wire clk,
  input wire ce,
  input wire rst_in,
  output reg rst_out
);

  reg stage_reg;

  // Assertion is taken at the next enabled edge; release ripples through
  // two stages. A low enable freezes both stages, reset included.
  always @(posedge clk)
  begin
    if (ce)
    begin
      if (rst_in)
      begin
        stage_reg <= 1'b1;
        rst_out <= 1'b1;
      end
      else
      begin
        stage_reg <= 1'b0;
        rst_out <= stage_reg; // [RULE_16]
      end
    end
  end

endmodule

// >>> verification/txcrm_pix_src.sv
// Pixel source model handing M and N stream ratio values to the block.
module txcrm_pix_src
#(
  parameter int H_TOTAL = 2200,
  parameter int V_TOTAL = 1125,
  parameter int FRAME_HZ = 60,
  parameter int PIX_PER_CLK = 4
)
(
  input wire logic ycc420,
  input wire logic [23:0] m_set,
  input wire logic [23:0] n_set,
  output logic [23:0] mvid_value,
  output logic [23:0] nvid_value,
  output logic [31:0] video_clock_khz
);
  timeunit 1ns;
  timeprecision 1ps;
  // Slowest video clock that still carries the whole frame timing.
  localparam int FULL_KHZ = H_TOTAL * V_TOTAL * FRAME_HZ / PIX_PER_CLK / 1000;
  // The source presents the ratio pair as level values.
  assign mvid_value = m_set;
  assign nvid_value = n_set;
  // The source runs its video clock at that minimum, halved for 4:2:0.
  assign video_clock_khz = ycc420 ? FULL_KHZ / 2 : FULL_KHZ;
endmodule

// >>> verification/txcrm_top_sva.sv
// Checker of decode, clock report and reset timing of txcrm_top.
module txcrm_sva
(
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire multi_stream,
  input wire [18:0] reg_addr,
  input wire [3:0] video_pipe_reset_req,
  input wire [3:0] stream_input_reset_req_n,
  input wire stream_output_reset_req_n,
  input wire [6:0] target_sel,
  input wire decode_miss,
  input wire [18:0] local_offset,
  input wire [8:0] link_clock_mhz,
  input wire [12:0] line_rate_mbps,
  input wire prog_reg_reset,
  input wire [3:0] video_pipe_reset,
  input wire [3:0] stream_input_reset_n,
  input wire stream_output_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Request patterns that reset outputs must follow.
  sequence vpr_req; (ce && video_pipe_reset_req[0])[*2]; endsequence
  sequence sin_free; (ce && stream_input_reset_req_n[1])[*6]; endsequence
  sequence sout_req; (ce && !stream_output_reset_req_n)[*2]; endsequence
  sequence bus_rst; (ce && !rst_n)[*2]; endsequence
  AST_SST_TC0: assert property (
    ce && !multi_stream && reg_addr[18:12] == 7'h01 |=> target_sel == 7'h02)
    else $error("single stream page one misrouted");
  AST_SST_PROT: assert property (
    ce && !multi_stream && reg_addr[18:12] == 7'h02 |=> target_sel == 7'h20)
    else $error("protection page misrouted");
  AST_MST_TC3: assert property (
    ce && multi_stream && reg_addr[18:12] == 7'h04 |=> target_sel == 7'h10)
    else $error("stream four timing page misrouted");
  AST_MST_NONE: assert property (
    ce && multi_stream |=> target_sel[6:5] == 2'h0)
    else $error("protection or timer selected in multi stream");
  AST_WINDOW: assert property (
    ce && reg_addr[18:12] > 7'h04 |=> decode_miss && local_offset[18:12] == 0)
    else $error("address outside window not missed");
  AST_LINE_DIV: assert property (
    line_rate_mbps == link_clock_mhz * 20)
    else $error("link clock not line rate over twenty");
  AST_VPR: assert property (vpr_req |=> video_pipe_reset[0])
    else $error("video pipe reset not asserted");
  AST_SIN: assert property (sin_free |=> stream_input_reset_n[1])
    else $error("stream input reset not released");
  AST_SOUT: assert property (sout_req |=> !stream_output_reset_n)
    else $error("stream output reset not asserted");
  AST_PROG: assert property (
    disable iff (1'b0) bus_rst |=> prog_reg_reset)
    else $error("program registers not reset");
  sequence sin_req; (ce && !stream_input_reset_req_n[0])[*2]; endsequence
  sequence bus_free; (ce && rst_n)[*3]; endsequence
  AST_SIN_REQ: assert property (
    sin_req |=> !stream_input_reset_n[0])
    else $error("stream input reset not asserted");
  AST_PROG_REL: assert property (
    bus_free |=> !prog_reg_reset)
    else $error("program register reset not released");
endmodule
bind txcrm_top txcrm_sva chk (.clk, .rst_n, .ce, .multi_stream, .reg_addr,
  .video_pipe_reset_req, .stream_input_reset_req_n, .stream_output_reset_req_n,
  .target_sel, .decode_miss, .local_offset, .link_clock_mhz, .line_rate_mbps,
  .prog_reg_reset, .video_pipe_reset, .stream_input_reset_n,
  .stream_output_reset_n);

// >>> verification/tb_txcrm_top.sv
// Self-checking bench of txcrm_top with a pixel source model.
module tb_txcrm_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, multi_stream = 1'b0;
  logic [18:0] reg_addr = 19'h00000;
  logic [1:0] link_rate_sel = 2'h0;
  logic [3:0] video_pipe_reset_req = 4'h0, stream_input_reset_req_n = 4'hf;
  logic stream_output_reset_req_n = 1'b1, decode_miss, prog_reg_reset;
  logic [23:0] m_set = 24'h000001, n_set = 24'h000001;
  logic [23:0] mvid_value, nvid_value, stream_m_value, stream_n_value;
  logic [6:0] target_sel;
  logic [18:0] local_offset;
  logic [8:0] link_clock_mhz, ext_prot_clock_mhz;
  logic [12:0] line_rate_mbps;
  logic [3:0] video_pipe_reset, stream_input_reset_n;
  logic stream_output_reset_n, ratio_valid;
  logic ycc420 = 1'b0;
  logic [31:0] video_clock_khz;
  logic [106:0] q[$], last, e, got;
  integer seed = 76204, err_total = 0, total_checks = 0, i;
  always #10 clk = ~clk;
  txcrm_pix_src src (.ycc420, .m_set, .n_set, .mvid_value, .nvid_value,
    .video_clock_khz);
  txcrm_top dut (.clk, .rst_n, .ce, .multi_stream, .reg_addr, .link_rate_sel,
    .video_pipe_reset_req, .stream_input_reset_req_n, .stream_output_reset_req_n,
    .mvid_value, .nvid_value, .target_sel, .decode_miss, .local_offset,
    .link_clock_mhz, .line_rate_mbps, .ext_prot_clock_mhz, .prog_reg_reset,
    .video_pipe_reset, .stream_input_reset_n, .stream_output_reset_n,
    .stream_m_value, .stream_n_value, .ratio_valid);
  // Expected outputs one cycle after the decode inputs.
  function automatic logic [106:0] expect_of(logic m, logic [18:0] a,
    logic [1:0] r, logic [23:0] mv, logic [23:0] nv);
    logic [6:0] s;
    logic [8:0] l;
    case (a[18:12])
      7'h00: s = 7'h01;
      7'h01: s = 7'h02;
      7'h02: s = m ? 7'h04 : 7'h20;
      7'h03: s = m ? 7'h08 : 7'h40;
      7'h04: s = m ? 7'h10 : 7'h00;
      default: s = 7'h00;
    endcase
    l = r == 2'h0 ? 9'h051 : r == 2'h1 ? 9'h087 : r == 2'h2 ? 9'h10e : 9'h195;
    return {s, s == 7'h00, 7'h00, a[11:0], l, 13'(l * 20), l >> 1, mv, nv,
      nv != 24'h0};
  endfunction
  // Compares one seen value with its expectation.
  task automatic check(logic [106:0] seen, logic [106:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Drives one cycle of inputs at the falling edge and notes the result.
  task automatic drive(logic c, logic m, logic [18:0] a);
    @(negedge clk);
    ce = c;
    multi_stream = m;
    reg_addr = a;
    link_rate_sel = 2'($random(seed));
    m_set = 24'($random(seed));
    n_set = ($random(seed) & 3) == 0 ? 24'h0 : 24'($random(seed));
    video_pipe_reset_req = 4'($random(seed));
    stream_input_reset_req_n = ~4'($random(seed) & $random(seed));
    stream_output_reset_req_n = 1'($random(seed));
    ycc420 = 1'($random(seed));
    if (c)
      last = expect_of(m, a, link_rate_sel, m_set, n_set);
    q.push_back(last);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Takes the oldest note once the sampling edge has updated the outputs.
  always @(posedge clk)
  begin
    #1;
    if (q.size() > 0)
    begin
      e = q.pop_front();
      got = {target_sel, decode_miss, local_offset, link_clock_mhz,
        line_rate_mbps, ext_prot_clock_mhz, stream_m_value, stream_n_value,
        ratio_valid};
      check(got[106:80], e[106:80]);
      check(got[79:0], e[79:0]);
      check(video_clock_khz, ycc420 ? 18562 : 37125);
    end
  end
  // Cuts a hang short.
  initial
  begin
    #(20 * 2000);
    err_total++;
    summarize();
  end
  // Every page in both maps, then random traffic with freezes and a bus reset three quarters through.
  initial
  begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    for (i = 0; i < 16; i++)
      drive(1'b1, i[3], {4'h0, i[2:0], 12'(i * 291)});
    for (i = 0; i < 400; i++)
    begin
      drive(($random(seed) & 7) != 0, 1'($random(seed)),
        {7'({$random(seed)} % 9), 12'($random(seed))});
      if (i == 300)
      begin
        @(negedge clk);
        {rst_n, ce, multi_stream, reg_addr} = {3'b010, 19'h0};
        last = '0; // Decode outputs read zero while the bus reset holds, then load page zero once it releases.
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
      end
    end
    repeat (3) @(negedge clk);
    summarize();
  end
endmodule
